// file: hw/counter_defs.svh
/*
 * Constants of the preset down counter: widths, count limits,
 * register offsets, field positions and reset values.
 * Assumes it is included by bare name and holds definitions only.
 */
`ifndef COUNTER_DEFS_SVH
`define COUNTER_DEFS_SVH

// Count width and the count limits
`define CNT_W 4
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
`define BCD_TOP 4'h9
`define BIN_TOP 4'hf

// Pin synchroniser: stage count and number of synchronised pins
`define SYNC_STAGES 2
`define PIN_W 9

// Settle count after reset: synchronisers plus edge history
`define SETTLE_W 2
`define SETTLE_ZERO 2'h0
`define SETTLE_ONE 2'h1
`define SETTLE_DONE 2'h3

// Positions of the pins inside the synchronised bundle
`define PIN_RISE 0
`define PIN_FALL 1
`define PIN_LOAD 2
`define PIN_CLEAR 3
`define PIN_CASCADE 4
`define PIN_PRESET_LO 5
`define PIN_PRESET_HI 8

// APB address width and register byte offsets
`define APB_ADDR_W 12
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004

// Control register fields and reset value
`define CTRL_BIN_BIT 0
`define CTRL_RESET 1'b0

// Status register fields
`define STAT_CNT_LO 0
`define STAT_CNT_HI 3
`define STAT_ZERO_BIT 4
`define STAT_CASCADE_BIT 5

// Zero word for read data
`define WORD_ZERO 32'h0000_0000

`endif

// file: hw/counter_pkg.sv
/*
 * Types shared by the preset down counter modules.
 * Assumes the constants header is compiled alongside.
 */
package counter_pkg;

   // Count value carried on every count port
   typedef logic [3:0] count_t;

   // Counting code of the counter
   typedef enum logic
   {
      variant_bcd,
      variant_binary
   } variant_t;

endpackage

// file: hw/count_step_if.sv
/*
 * Interface between the counter core and its decrement logic.
 * Assumes both ends share the package types.
 */
`timescale 1ns/1ps

interface count_step_if;
   import counter_pkg::*;

   count_t count; // Present count
   variant_t variant; // Decimal or binary code
   count_t next_count; // Count after one decrement

   // Counter core side
   modport core
   (
      output count,
      output variant,
      input next_count
   );

   // Decrement logic side
   modport step
   (
      input count,
      input variant,
      output next_count
   );
endinterface

// file: hw/pin_sync.sv
/*
 * Bank of two-stage synchronisers for asynchronous pins.
 * Assumes one clock and a synchronous active low reset.
 */
`timescale 1ns/1ps
`include "counter_defs.svh"

module pin_sync
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [`PIN_W-1:0] pin_async,
   output logic [`PIN_W-1:0] pin_sync_out
);
   import counter_pkg::*;

   // One synchroniser per pin
   genvar g;
   generate
      for (g = 0; g < `PIN_W; g = g + 1)
      begin : g_bit
         logic meta; // First stage, read only by the second

         // Two flip-flops in series
         always_ff @(posedge clk)
         begin
            if (!rstn)
            begin
               meta <= 1'b0;
               pin_sync_out[g] <= 1'b0;
            end
            else
            begin
               meta <= pin_async[g];
               pin_sync_out[g] <= meta;
            end
         end
      end
   endgenerate
endmodule

// file: hw/count_step.sv
/*
 * Decrement logic of the down counter in decimal and binary code.
 * Assumes the core feeds the present count and code.
 */
`timescale 1ns/1ps
`include "counter_defs.svh"

module count_step
(
   count_step_if.step port
);
   import counter_pkg::*;

   // Next value: wrap from zero to the top of the code
   always_comb
   begin
      if (port.count == `CNT_ZERO)
      begin
         // Decimal wraps to nine, binary to fifteen
         port.next_count = (port.variant == variant_bcd) ? `BCD_TOP : `BIN_TOP;
      end
      else
      begin
         // Plain decrement in either code
         port.next_count = port.count - `CNT_ONE;
      end
   end
endmodule

// file: hw/preset_down_counter.sv
/*
 * Programmable 4-bit down counter with two count clock pins, preset
 * load, overriding clear, terminal-count output and an APB register
 * port selecting decimal or binary code and showing the count.
 * Assumes all pins are asynchronous to clk and the APB master runs on clk.
 */
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`include "counter_defs.svh"

// Functional notes
// - Load high, clear low: preset copied in
// - Clear wins over load
// - Load and falling clock low: count on rise
// - Load low, rising clock high: count on fall
// - Zero flag: count zero and cascade high
// - Clear forces count to zero at the third clk edge after the pin rises
// - Decimal variant counts down in BCD
// - Binary variant counts down in binary
module preset_down_counter
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic rising_count_clock,
   input wire logic falling_count_clock,
   input wire logic preset_strobe,
   input wire logic [3:0] preset_value,
   input wire logic cascade_in,
   input wire logic clear_input,
   output counter_pkg::count_t count_value,
   output logic zero_flag_out,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`APB_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import counter_pkg::*;

   logic [`PIN_W-1:0] pins_raw; // Pins before synchronising
   logic [`PIN_W-1:0] pins; // Pins after two flip-flops
   logic rise_clk; // Synchronised rising count clock
   logic fall_clk; // Synchronised falling count clock
   logic load; // Synchronised preset strobe
   logic clear; // Synchronised clear
   logic cascade; // Synchronised cascade input
   count_t preset; // Synchronised preset value
   logic rise_clk_prev; // Rising clock one cycle back
   logic fall_clk_prev; // Falling clock one cycle back
   logic rise_edge; // Low-to-high seen on rising clock
   logic fall_edge; // High-to-low seen on falling clock
   logic rise_count; // Enabled count on rising edge
   logic fall_count; // Enabled count on falling edge
   logic dec; // One decrement this cycle
   variant_t variant; // Code selected by software
   logic sel_ctrl; // Address hits control register
   logic sel_status; // Address hits status register
   logic mapped; // Address hits any register
   logic apb_write; // Write takes effect this edge
   logic apb_setup; // Setup phase of a transfer
   logic [`SETTLE_W-1:0] settle; // Edges since reset, stops when armed
   logic armed; // Edge history holds real pin levels

   count_step_if step_bus();

   // Gather the pins into one bundle for the synchronisers
   assign pins_raw[`PIN_RISE] = rising_count_clock;
   assign pins_raw[`PIN_FALL] = falling_count_clock;
   assign pins_raw[`PIN_LOAD] = preset_strobe;
   assign pins_raw[`PIN_CLEAR] = clear_input;
   assign pins_raw[`PIN_CASCADE] = cascade_in;
   assign pins_raw[`PIN_PRESET_HI:`PIN_PRESET_LO] = preset_value;

   // Two flip-flops on every pin before any logic reads it
   pin_sync u_sync
   (
      .clk(clk),
      .rstn(rstn),
      .pin_async(pins_raw),
      .pin_sync_out(pins)
   );

   assign rise_clk = pins[`PIN_RISE];
   assign fall_clk = pins[`PIN_FALL];
   assign load = pins[`PIN_LOAD];
   assign clear = pins[`PIN_CLEAR];
   assign cascade = pins[`PIN_CASCADE];
   assign preset = pins[`PIN_PRESET_HI:`PIN_PRESET_LO];

   // Decrement logic sees the present count and code
   assign step_bus.count = count_value;
   assign step_bus.variant = variant;

   count_step u_step
   (
      .port(step_bus.step)
   );

   // Previous levels of both count clocks for edge detection
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         rise_clk_prev <= 1'b0;
         fall_clk_prev <= 1'b0;
      end
      else
      begin
         rise_clk_prev <= rise_clk;
         fall_clk_prev <= fall_clk;
      end
   end

   // Edges since reset, held once the pin history is real
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         settle <= `SETTLE_ZERO;
      end
      else if (!armed)
      begin
         // Count until synchronisers and history are filled
         settle <= settle + `SETTLE_ONE;
      end
   end

   // No edge is believed before the history holds real pin levels
   assign armed = (settle == `SETTLE_DONE);

   // Edge detectors on the synchronised clocks
   // A pin held high through reset would otherwise look like a fresh edge
   assign rise_edge = armed && rise_clk && !rise_clk_prev;
   assign fall_edge = armed && !fall_clk && fall_clk_prev;

   // Rising edge counts while load and falling clock are low
   assign rise_count = rise_edge && !load && !fall_clk;
   // Falling edge counts while load is low and rising clock high
   assign fall_count = fall_edge && !load && rise_clk;
   // Any other clock combination yields no decrement
   assign dec = rise_count || fall_count;

   // Count register: clear, then load, then decrement, else hold
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         count_value <= `CNT_ZERO;
      end
      else if (clear)
      begin
         // Clear overrides load and both clocks
         count_value <= `CNT_ZERO;
      end
      else if (load)
      begin
         // Preset copied whatever the clocks do
         count_value <= preset;
      end
      else if (dec)
      begin
         // All four bits change together
         count_value <= step_bus.next_count;
      end
   end

   // Terminal count flag from the zero state and cascade input
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         zero_flag_out <= 1'b0;
      end
      else
      begin
         // High only for zero count with cascade high
         zero_flag_out <= (count_value == `CNT_ZERO) && cascade;
      end
   end

   // APB address decode and phases
   assign sel_ctrl = (paddr == `ADDR_CTRL);
   assign sel_status = (paddr == `ADDR_STATUS);
   assign mapped = sel_ctrl || sel_status;
   assign apb_setup = psel && !penable;
   assign apb_write = psel && penable && pwrite;

   // Zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Control register: code selection written by software
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         variant <= variant_t'(`CTRL_RESET);
      end
      else if (apb_write && sel_ctrl)
      begin
         // Bit set selects binary, clear selects decimal
         variant <= variant_t'(pwdata[`CTRL_BIN_BIT]);
      end
   end

   // Read data captured in the setup phase, valid through access
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         prdata <= `WORD_ZERO;
      end
      else if (apb_setup)
      begin
         prdata <= `WORD_ZERO;
         if (!pwrite && sel_ctrl)
         begin
            // Present code selection
            prdata[`CTRL_BIN_BIT] <= (variant == variant_binary);
         end
         else if (!pwrite && sel_status)
         begin
            // Count, terminal flag and cascade level
            prdata[`STAT_CNT_HI:`STAT_CNT_LO] <= count_value;
            prdata[`STAT_ZERO_BIT] <= zero_flag_out;
            prdata[`STAT_CASCADE_BIT] <= cascade;
         end
      end
   end

   // Checks on the counter behaviour
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // Load with clear low takes the preset
   property p_load;
      (load && !clear) |=> (count_value == $past(preset));
   endproperty
   a_load: assert property (p_load) else $error("preset not loaded");

   // Clear with load keeps the count at zero
   property p_clear_over_load;
      (clear && load) |=> (count_value == `CNT_ZERO);
   endproperty
   a_clear_over_load: assert property (p_clear_over_load) else $error("load beat clear");

   // Rising clock count takes the decrement value
   property p_rise;
      (rise_edge && !fall_clk && !load && !clear) |=> (count_value == $past(step_bus.next_count));
   endproperty
   a_rise: assert property (p_rise) else $error("rising edge count missed");

   // Falling clock count takes the decrement value
   property p_fall;
      (fall_edge && rise_clk && !load && !clear) |=> (count_value == $past(step_bus.next_count));
   endproperty
   a_fall: assert property (p_fall) else $error("falling edge count missed");

   // Flag follows zero count and cascade one cycle later
   property p_zero_flag;
      ##1 (zero_flag_out == ($past(count_value) == `CNT_ZERO && $past(cascade)));
   endproperty
   a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

   // Clear holds zero for as long as it stays high
   property p_clear;
      clear [*2] |=> (count_value == `CNT_ZERO) && (zero_flag_out == $past(cascade));
   endproperty
   a_clear: assert property (p_clear) else $error("clear did not zero count");

   // Decimal count never leaves the decimal range by counting
   property p_bcd_range;
      (variant == variant_bcd && count_value <= `BCD_TOP && !load && !clear) |=> (count_value <= `BCD_TOP);
   endproperty
   a_bcd_range: assert property (p_bcd_range) else $error("decimal count out of range");

   // Binary count goes down by exactly one from nonzero
   property p_bin_dec;
      (variant == variant_binary && dec && count_value != `CNT_ZERO && !load && !clear)
         |=> (count_value == $past(count_value) - `CNT_ONE);
   endproperty
   a_bin_dec: assert property (p_bin_dec) else $error("binary decrement wrong");

   // Wrap from zero to the code's top value
   property p_wrap;
      (dec && count_value == `CNT_ZERO && !load && !clear)
         |=> (count_value == (($past(variant) == variant_bcd) ? `BCD_TOP : `BIN_TOP));
   endproperty
   a_wrap: assert property (p_wrap) else $error("wrap value wrong");

   // No clear, load or enabled edge keeps the count
   property p_hold;
      (!clear && !load && !dec) |=> $stable(count_value);
   endproperty
   a_hold: assert property (p_hold) else $error("count changed without cause");

   // Only a write to the control register moves the code
   property p_variant_hold;
      (!(apb_write && sel_ctrl)) |=> $stable(variant);
   endproperty
   a_variant_hold: assert property (p_variant_hold) else $error("code changed without control write");

   // Main scenarios
   c_wrap_bcd: cover property (dec && count_value == `CNT_ZERO && variant == variant_bcd);
   c_fall_count: cover property (fall_count);
   c_load_then_count: cover property (load ##1 !load [*2] ##1 rise_count);
   c_flag_high: cover property (zero_flag_out);
   c_wrap_bin: cover property (dec && count_value == `CNT_ZERO && variant == variant_binary);
endmodule

// file: sim/pin_driver.sv
/*
 * Model of the surrounding logic that drives the counter pins.
 * Assumes the caller runs on the same clk; every pin moves just after a rising edge.
 */
`timescale 1ns/1ps

module pin_driver
(
   input wire logic clk,
   output logic rising_count_clock,
   output logic falling_count_clock,
   output logic preset_strobe,
   output logic [3:0] preset_value,
   output logic cascade_in,
   output logic clear_input
);
   // All pins quiet from time zero
   initial
   begin
      rising_count_clock = 1'b0;
      falling_count_clock = 1'b0;
      preset_strobe = 1'b0;
      preset_value = 4'h0;
      cascade_in = 1'b0;
      clear_input = 1'b0;
   end

   // Set every pin level, the preset only with the strobe, then hold long enough for sync, update and flag
   task automatic drive(input logic r, input logic f, input logic l, input logic c, input logic k,
                        input logic [3:0] p);
      @(posedge clk);
      rising_count_clock <= r;
      falling_count_clock <= f;
      preset_strobe <= l;
      clear_input <= c;
      cascade_in <= k;
      // A new preset moves only together with a high strobe
      if (l)
      begin
         preset_value <= p;
      end
      // With the strobe low, the lines stay put two cycles, then carry junk
      repeat (2) @(posedge clk);
      if (!l)
      begin
         preset_value <= ~p;
      end
      repeat (4) @(posedge clk);
   endtask
endmodule

// file: sim/preset_down_counter_tb.sv
/*
 * Self-checking bench of the preset down counter: pins through the driver model, registers over APB.
 * Assumes the design counts three clk edges behind its pins; APB waits follow pready.
 */
`timescale 1ns/1ps

module preset_down_counter_tb;
   import counter_pkg::*;

   logic clk = 1'b0; // Bench clock, 50 ns
   logic rstn = 1'b0; // Synchronous reset
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic rise_pin, fall_pin, load_pin, clear_pin, casc_pin; // Pin wires from the model
   logic [3:0] preset_pin;
   count_t count_value;
   logic zero_flag_out;
   int num_errors = 0;
   int checks = 0;

   // Clock generator
   always #25 clk = ~clk;

   // Surrounding logic model
   pin_driver u_pins (.clk(clk), .rising_count_clock(rise_pin), .falling_count_clock(fall_pin),
      .preset_strobe(load_pin), .preset_value(preset_pin), .cascade_in(casc_pin), .clear_input(clear_pin));

   // Device under test
   preset_down_counter u_dut (.clk(clk), .rstn(rstn), .rising_count_clock(rise_pin),
      .falling_count_clock(fall_pin), .preset_strobe(load_pin), .preset_value(preset_pin),
      .cascade_in(casc_pin), .clear_input(clear_pin), .count_value(count_value),
      .zero_flag_out(zero_flag_out), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // One APB transfer, held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [31:0] exp,
                      input logic experr);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees pready
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      if (!wr)
         chk(prdata, exp, "read data");
      chk({31'h0, pslverr}, {31'h0, experr}, "slave error");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Drive pins, then compare count and zero flag
   task automatic step(input logic r, input logic f, input logic l, input logic c, input logic k,
                       input logic [3:0] p, input logic [3:0] exp);
      u_pins.drive(r, f, l, c, k, p);
      chk({28'h0, count_value}, {28'h0, exp}, "count");
      chk({31'h0, zero_flag_out}, {31'h0, (exp == 4'h0) && k}, "zero flag");
   endtask

   // Verdict and end of run
   task automatic stop_test;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Watchdog against a hang
   initial
   begin
      repeat (5000) @(posedge clk);
      num_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      stop_test;
   end

   // Main sequence
   initial
   begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      chk({28'h0, count_value}, 32'h0000_0000, "reset count");
      apb(1'b0, 12'h000, 32'h0, 32'h0000_0000, 1'b0);
      apb(1'b0, 12'h004, 32'h0, 32'h0000_0000, 1'b0);
      $display("test reset done");
      step(1, 1, 1, 0, 0, 4'h3, 4'h3);
      step(1, 1, 0, 0, 0, 4'h3, 4'h3);
      step(1, 0, 0, 0, 0, 4'h3, 4'h2);
      step(0, 0, 0, 0, 0, 4'h3, 4'h2);
      step(1, 0, 0, 0, 0, 4'h3, 4'h1);
      step(0, 0, 0, 0, 0, 4'h3, 4'h1);
      step(0, 1, 0, 0, 0, 4'h3, 4'h1);
      step(0, 0, 0, 0, 0, 4'h3, 4'h1);
      step(1, 0, 0, 0, 0, 4'h3, 4'h0);
      step(1, 0, 0, 0, 1, 4'h3, 4'h0);
      apb(1'b0, 12'h004, 32'h0, 32'h0000_0030, 1'b0);
      step(0, 0, 0, 0, 1, 4'h3, 4'h0);
      step(1, 0, 0, 0, 0, 4'h3, 4'h9);
      apb(1'b0, 12'h004, 32'h0, 32'h0000_0009, 1'b0);
      $display("test clock edges done");
      step(0, 0, 1, 0, 0, 4'h5, 4'h5);
      step(1, 0, 1, 0, 0, 4'h5, 4'h5);
      step(1, 0, 1, 1, 1, 4'h5, 4'h0);
      step(0, 0, 0, 1, 1, 4'h5, 4'h0);
      step(1, 0, 0, 1, 1, 4'h5, 4'h0);
      $display("test load and clear done");
      apb(1'b1, 12'h000, 32'h0000_0001, 32'h0, 1'b0);
      apb(1'b0, 12'h000, 32'h0, 32'h0000_0001, 1'b0);
      step(0, 0, 0, 0, 0, 4'h0, 4'h0);
      step(1, 0, 0, 0, 0, 4'h0, 4'hf);
      step(0, 0, 0, 0, 0, 4'h0, 4'hf);
      step(1, 0, 0, 0, 0, 4'h0, 4'he);
      step(1, 0, 1, 0, 0, 4'hb, 4'hb);
      step(1, 0, 0, 0, 0, 4'hb, 4'hb);
      step(1, 1, 0, 0, 0, 4'hb, 4'hb);
      step(1, 0, 0, 0, 0, 4'hb, 4'ha);
      apb(1'b1, 12'h004, 32'h0000_00ff, 32'h0, 1'b0);
      apb(1'b0, 12'h004, 32'h0, 32'h0000_000a, 1'b0);
      apb(1'b1, 12'h008, 32'h0000_0001, 32'h0, 1'b1);
      apb(1'b0, 12'h008, 32'h0, 32'h0000_0000, 1'b1);
      apb(1'b0, 12'h000, 32'h0, 32'h0000_0001, 1'b0);
      $display("test binary and registers done");
      stop_test;
   end
endmodule
